// ==== rtl/dtc_map.vh ====
// Constants for the termination control block: field positions, resets and latencies.
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
`define DTC_CFG_RESET 8'h00
`define DTC_OVR_RESET 8'h00
`define DTC_CA_STR_HI 6
`define DTC_CA_STR_LO 4
`define DTC_DQ_STR_HI 2
`define DTC_DQ_STR_LO 0
`define DTC_OVR_CK_BIT 3
`define DTC_OVR_CS_BIT 4
`define DTC_OVR_CA_BIT 5
`define DTC_CA_UPDATE_CYCLES 4
`define DTC_TERM_ON_LATENCY 12
`define DTC_TERM_OFF_LATENCY 28
`define DTC_BL32_EXTRA_CYCLES 8
`endif

// ==== rtl/dtc_termination_ctrl.v ====
// On-die termination control for the command/address and data pin groups.
// Summary of operation
// - CA strength from config bits 6 to 4.
// - CA termination off after reset until programmed.
// - CA termination on clock, chip select, CA lines.
// - Zero strength disables all; override bits disable groups.
// - Power-down leaves CA termination unchanged.
// - CA termination controlled only by mode registers.
// - Data termination strength from bits 2 to 0.
// - Data termination on data, strobes, mask pin.
// - First write command part arms; second column command starts data termination.
// - No data termination in power-down or self-refresh.
// - Data termination window after latency, off after burst.
// - Write leveling: strobes terminated, data lines not.
`include "dtc_map.vh"
module dtc_termination_ctrl #(
  parameter ON_LAT = `DTC_TERM_ON_LATENCY,
  parameter OFF_LAT = `DTC_TERM_OFF_LATENCY,
  parameter CA_UPD = `DTC_CA_UPDATE_CYCLES,
  parameter CW = 6
)
(
  input wire ref_clk,
  input wire rstn,
  input wire mrw_cfg_valid,
  input wire mrw_ovr_valid,
  input wire [7:0] mrw_data,
  input wire write_first,
  input wire write_cas2,
  input wire burst32,
  input wire power_down,
  input wire self_refresh,
  input wire write_leveling,
  output wire [7:0] termination_config,
  output wire [7:0] ca_termination_override,
  output reg [2:0] ca_term_strength,
  output reg ca_term_en,
  output reg clk_term_en,
  output reg chipsel_term_en,
  output reg [2:0] dq_term_strength,
  output reg dq_term_en,
  output reg dqs_term_en,
  output reg mask_inversion_term_en,
  output wire write_pending
);
  reg [7:0] cfg_q;
  reg [7:0] ovr_q;
  // Write sequencer states: bit 0 marks an armed write, bit 1 an open window.
  localparam [1:0] WR_IDLE = 2'h0;
  localparam [1:0] WR_ARMED = 2'h1;
  localparam [1:0] WR_OPEN = 2'h2;
  localparam [1:0] WR_OPEN_ARMED = 2'h3;
  localparam BL32_EXTRA = `DTC_BL32_EXTRA_CYCLES;
  localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
  reg [CW-1:0] upd_cnt_q;
  reg [1:0] wr_state_q;
  reg [1:0] wr_state_d;
  reg [CW-1:0] dq_cnt_q;
  reg [CW-1:0] off_q;
  wire [2:0] ca_str;
  wire [2:0] dq_str;
  wire dq_mode;
  wire dq_window;
  wire arm_req;
  wire wr_start;
  wire win_end;

  // One CA-side pin group: a zero strength leaves every group open.
  function dtc_group_on;
    input [2:0] strength;
    input disable_bit;
    begin
      dtc_group_on = (strength != 3'h0) && !disable_bit;
    end
  endfunction

  assign termination_config = cfg_q;
  assign ca_termination_override = ovr_q;
  assign ca_str = cfg_q[`DTC_CA_STR_HI:`DTC_CA_STR_LO];
  assign dq_str = cfg_q[`DTC_DQ_STR_HI:`DTC_DQ_STR_LO];
  assign dq_mode = (dq_str != 3'h0);
  assign arm_req = write_first && dq_mode;
  assign wr_start = write_cas2 && wr_state_q[0];
  assign win_end = (dq_cnt_q >= off_q);
  assign write_pending = (wr_state_q != WR_IDLE);
  // Window opens once the on-latency has elapsed and lasts until the off-latency.
  assign dq_window = wr_state_q[1] && (dq_cnt_q >= ON_LAT[CW-1:0]) && !win_end;

  // Mode registers are the only control path; no termination pin exists.
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cfg_q <= `DTC_CFG_RESET;
      ovr_q <= `DTC_OVR_RESET;
    end
    else
    begin
      if (mrw_cfg_valid)
        cfg_q <= mrw_data;
      if (mrw_ovr_valid)
        ovr_q <= mrw_data;
    end
  end

  // CA pins only see a new setting after a fixed settling count, so a
  // controller issuing commands right after the write sees stable loading.
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      upd_cnt_q <= {CW{1'b0}};
      ca_term_strength <= 3'h0;
      ca_term_en <= 1'b0;
      clk_term_en <= 1'b0;
      chipsel_term_en <= 1'b0;
    end
    else if (mrw_cfg_valid || mrw_ovr_valid)
      upd_cnt_q <= CA_UPD[CW-1:0];
    else if (upd_cnt_q != {CW{1'b0}})
    begin
      upd_cnt_q <= upd_cnt_q - {{(CW-1){1'b0}}, 1'b1};
      if (upd_cnt_q == {{(CW-1){1'b0}}, 1'b1})
      begin
        // Power-down is not consulted, keeping alternate ranks terminated.
        ca_term_strength <= ca_str;
        ca_term_en <= dtc_group_on(ca_str, ovr_q[`DTC_OVR_CA_BIT]);
        clk_term_en <= dtc_group_on(ca_str, ovr_q[`DTC_OVR_CK_BIT]);
        chipsel_term_en <= dtc_group_on(ca_str, ovr_q[`DTC_OVR_CS_BIT]);
      end
    end
  end

  // Write sequencing: the first part arms, the second column command starts the count.
  // A write may be armed while a window is still open, so a second write restarts
  // the window from its own second column command instead of being lost.
  always @*
  begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
      WR_IDLE:
      begin
        if (arm_req)
          wr_state_d = WR_ARMED;
        else
          wr_state_d = WR_IDLE;
      end
      WR_ARMED:
      begin
        if (arm_req)
          wr_state_d = write_cas2 ? WR_OPEN_ARMED : WR_ARMED;
        else
          wr_state_d = write_cas2 ? WR_OPEN : WR_ARMED;
      end
      WR_OPEN:
      begin
        if (arm_req)
          wr_state_d = win_end ? WR_ARMED : WR_OPEN_ARMED;
        else
          wr_state_d = win_end ? WR_IDLE : WR_OPEN;
      end
      WR_OPEN_ARMED:
      begin
        if (write_cas2)
          wr_state_d = arm_req ? WR_OPEN_ARMED : WR_OPEN;
        else
          wr_state_d = win_end ? WR_ARMED : WR_OPEN_ARMED;
      end
      default:
        wr_state_d = WR_IDLE;
    endcase
  end

  // The off point is latched at the second column command, because the burst
  // length is only valid alongside that command.
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      wr_state_q <= WR_IDLE;
      dq_cnt_q <= {CW{1'b0}};
      off_q <= {CW{1'b0}};
    end
    else if (power_down || self_refresh)
    begin
      // A write cut short by a low-power state is dropped, not resumed.
      wr_state_q <= WR_IDLE;
      dq_cnt_q <= {CW{1'b0}};
    end
    else
    begin
      wr_state_q <= wr_state_d;
      if (wr_start)
      begin
        dq_cnt_q <= {CW{1'b0}};
        off_q <= burst32 ? OFF_LAT[CW-1:0] + BL32_EXTRA[CW-1:0] : OFF_LAT[CW-1:0];
      end
      else if (wr_state_q[1] && !win_end)
        dq_cnt_q <= dq_cnt_q + CNT_ONE;
    end
  end

  // Data group enables; a write cut short by power-down drops them at once.
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      dq_term_strength <= 3'h0;
      dq_term_en <= 1'b0;
      dqs_term_en <= 1'b0;
      mask_inversion_term_en <= 1'b0;
    end
    else
    begin
      dq_term_strength <= dq_str;
      if (power_down || self_refresh || !dq_mode)
      begin
        dq_term_en <= 1'b0;
        dqs_term_en <= 1'b0;
        mask_inversion_term_en <= 1'b0;
      end
      else if (write_leveling)
      begin
        dq_term_en <= 1'b0;
        dqs_term_en <= 1'b1;
        mask_inversion_term_en <= 1'b0;
      end
      else
      begin
        dq_term_en <= dq_window;
        dqs_term_en <= dq_window;
        mask_inversion_term_en <= dq_window;
      end
    end
  end
endmodule

// ==== testbench/dtc_chk.sv ====
// Port assertions for the termination control block.
module dtc_chk (
  input wire ref_clk,
  input wire rstn,
  input wire mrw_cfg_valid,
  input wire mrw_ovr_valid,
  input wire [7:0] mrw_data,
  input wire power_down,
  input wire self_refresh,
  input wire [7:0] termination_config,
  input wire [7:0] ca_termination_override,
  input wire [2:0] ca_term_strength,
  input wire ca_term_en,
  input wire clk_term_en,
  input wire chipsel_term_en,
  input wire [2:0] dq_term_strength,
  input wire dq_term_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_quiet; !mrw_cfg_valid && !mrw_ovr_valid; endsequence
  property p_cfg; mrw_cfg_valid |=> termination_config == $past(mrw_data); endproperty
  a_cfg: assert property (p_cfg) else $error("cfg");
  property p_ovr; mrw_ovr_valid |=> ca_termination_override == $past(mrw_data); endproperty
  a_ovr: assert property (p_ovr) else $error("ovr");
  property p_off; ca_term_strength == 3'h0 |-> !(ca_term_en | clk_term_en | chipsel_term_en);
  endproperty
  a_off: assert property (p_off) else $error("ca off");
  property p_late; mrw_cfg_valid |=> $stable(ca_term_strength)[*2]; endproperty
  a_late: assert property (p_late) else $error("early");
  property p_hold; s_quiet[*6] |-> $stable(ca_term_strength) && $stable(ca_term_en); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_dqs; dq_term_strength == $past(termination_config[2:0]); endproperty
  a_dqs: assert property (p_dqs) else $error("dq str");
  property p_dqz; dq_term_en |-> dq_term_strength != 3'h0; endproperty
  a_dqz: assert property (p_dqz) else $error("dq zero");
  property p_pd; (power_down || self_refresh)[*2] |-> !dq_term_en; endproperty
  a_pd: assert property (p_pd) else $error("pd");
endmodule
bind dtc_termination_ctrl dtc_chk i_dtc_chk (.*);

// ==== testbench/dtc_ctrl_model.sv ====
// Memory controller model: mode register writes, write commands and power states.
module dtc_ctrl_model (
  input wire ref_clk,
  output reg mrw_cfg_valid = 1'h0,
  output reg mrw_ovr_valid = 1'h0,
  output reg [7:0] mrw_data = 8'h00,
  output reg write_first = 1'h0,
  output reg write_cas2 = 1'h0,
  output reg burst32 = 1'h0,
  output reg power_down = 1'h0,
  output reg self_refresh = 1'h0,
  output reg write_leveling = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // A single rank is modelled, so it is the only terminator and is set first.
  task mrw(input logic o, input logic [7:0] d);
    @(posedge ref_clk);
    {mrw_ovr_valid, mrw_cfg_valid, mrw_data} <= {o, !o, d};
    @(posedge ref_clk);
    {mrw_ovr_valid, mrw_cfg_valid, mrw_data} <= {2'h0, ~d};
  endtask
  task wr(input logic b);
    @(posedge ref_clk);
    write_first <= 1'h1;
    @(posedge ref_clk);
    {write_first, write_cas2, burst32} <= {2'h1, b};
    @(posedge ref_clk);
    {write_cas2, burst32} <= {1'h0, ~b};
  endtask
  task lvl(input logic [2:0] v);
    @(posedge ref_clk);
    {write_leveling, self_refresh, power_down} <= v;
  endtask
endmodule

// ==== testbench/dtc_termination_ctrl_tb_top.sv ====
// Self-checking bench for the termination control block.
module dtc_termination_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  int err_count = 0;
  int comparisons = 0;
  wire mrw_cfg_valid, mrw_ovr_valid, write_first, write_cas2, burst32, power_down;
  wire self_refresh, write_leveling, ca_term_en, clk_term_en, chipsel_term_en;
  wire dq_term_en, dqs_term_en, mask_inversion_term_en, write_pending;
  wire [7:0] mrw_data, termination_config, ca_termination_override;
  wire [2:0] ca_term_strength, dq_term_strength;
  wire [7:0] ca_obs;
  assign ca_obs = {2'h0, ca_term_strength, ca_term_en, clk_term_en, chipsel_term_en};
  dtc_ctrl_model i_dtc_ctrl_model (.*);
  dtc_termination_ctrl #(.ON_LAT(2), .OFF_LAT(6)) i_dtc_termination_ctrl (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task complete_run;
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task t_ca;
    logic [2:0] s;
    logic [7:0] e;
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      s = (i == 7) ? 3'h6 : 3'(i);
      i_dtc_ctrl_model.mrw(1'h1, 8'(i << 3));
      i_dtc_ctrl_model.mrw(1'h0, {1'h0, s, 4'h0});
      repeat (4) @(negedge ref_clk);
      chk(ca_obs, p);
      repeat (2) @(negedge ref_clk);
      e = {2'h0, s, s != 0 && !i[2], s != 0 && !i[0], s != 0 && !i[1]};
      chk(ca_obs, e);
      p = e;
    end
  endtask
  // Counts every data termination output, so a strobe or mask left unterminated shows too.
  task t_dq(input logic [7:0] c, input logic b, input int n);
    int k;
    k = 0;
    i_dtc_ctrl_model.mrw(1'h0, c);
    i_dtc_ctrl_model.wr(b);
    @(negedge ref_clk);
    chk({7'h0, write_pending}, {7'h0, c[2:0] != 3'h0});
    repeat (39) @(negedge ref_clk) k += dq_term_en + dqs_term_en + mask_inversion_term_en;
    chk(8'(k), 8'(n));
    chk({7'h0, write_pending}, 8'h00);
  endtask
  task t_pd;
    int a, b;
    i_dtc_ctrl_model.mrw(1'h1, 8'h00);
    i_dtc_ctrl_model.mrw(1'h0, 8'h53);
    for (int v = 1; v < 3; v++)
    begin
      a = 0;
      b = 0;
      i_dtc_ctrl_model.lvl(3'(v));
      i_dtc_ctrl_model.wr(1'h0);
      repeat (20) @(negedge ref_clk) {a, b} = {a + dq_term_en, b + ca_term_en};
      chk(8'(a), 8'h00);
      chk(8'(b), 8'h14);
    end
    i_dtc_ctrl_model.lvl(3'h4);
    repeat (3) @(negedge ref_clk);
    chk({5'h0, dq_term_en, dqs_term_en, mask_inversion_term_en}, 8'h02);
  endtask
  // A mid-run reset must drop the CA termination programmed before it.
  task t_rst;
    @(posedge ref_clk);
    rstn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    @(negedge ref_clk);
    chk(ca_obs, 8'h00);
    chk(termination_config | ca_termination_override, 8'h00);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'h1;
    @(negedge ref_clk);
    chk({5'h0, ca_term_en, clk_term_en, chipsel_term_en}, 8'h00);
    t_ca;
    t_dq(8'h53, 1'h0, 12);
    t_dq(8'h53, 1'h1, 36);
    t_dq(8'h50, 1'h0, 0);
    t_pd;
    t_rst;
    complete_run;
  end
  initial
  begin
    #100us;
    err_count++;
    complete_run;
  end
endmodule
